/* design/rxirq_sample_hold.sv */
`timescale 1ns/1ps
`include "rxirq_defines.svh"

module rxirq_sample_hold (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic sample_strobe,
    input wire rxirq_pkg::rxirq_sample_type sample_in,
    input wire logic sample_err,
    input wire logic [1:0] hold_mode,
    output rxirq_pkg::rxirq_sample_type sample_out,
    output logic sample_out_valid
);

    rxirq_pkg::rxirq_sample_type last_good_ff;

    // ********************************************************
    // remember the last sample that arrived without error
    // ********************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_good_ff <= '0;
        end else if (sample_strobe && !sample_err) begin
            last_good_ff <= sample_in;
        end
    end

    // output sample with the error action applied
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sample_out <= '0;
        end else if (sample_strobe) begin
            if (!sample_err) begin
                sample_out <= sample_in;
            end else begin
                unique case (hold_mode)
                    `RXIRQ_HOLD_LAST: sample_out <= last_good_ff;
                    `RXIRQ_HOLD_ZERO: sample_out <= '0;
                    // pass and the reserved code leave it alone
                    default: sample_out <= sample_in;
                endcase
            end
        end
    end

    // one-cycle strobe beside each output sample
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sample_out_valid <= 1'b0;
        end else begin
            sample_out_valid <= sample_strobe;
        end
    end

endmodule : rxirq_sample_hold

/* design/rxirq_top.sv */
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "rxirq_defines.svh"

module rxirq_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic user_buf_update,
    input wire logic cbuf_update,
    input wire logic qch_update,
    input wire logic adc_ovfl_left,
    input wire logic adc_ovfl_right,
    input wire logic pll_unlocked,
    input wire logic subframe_strobe,
    input wire logic sf_validity,
    input wire logic sf_line_code_error,
    input wire logic sf_odd_even_fail,
    input wire rxirq_pkg::rxirq_sample_type sf_sample,
    input wire logic qsub_block_strobe,
    input wire logic qsub_crc_fail,
    input wire logic cs_block_strobe,
    input wire logic cs_crc_fail,
    input wire logic receiver_in_use,
    input wire logic [9:0] cs_side_a,
    input wire logic [9:0] cs_side_b,
    input wire rxirq_pkg::rxirq_byte_type cbuf_byte_a,
    input wire rxirq_pkg::rxirq_byte_type cbuf_byte_b,
    input wire rxirq_pkg::rxirq_byte_type ubuf_byte,
    output rxirq_pkg::rxirq_byte_type buf_index,
    output logic [1:0] pll_tracking_mode,
    output logic buffer_content_select,
    output logic buffer_access_width,
    output logic subframe_side_select,
    output rxirq_pkg::rxirq_sample_type sample_out,
    output logic sample_out_valid,
    output logic int_pin_out,
    output logic int_pin_oe
);

    // ********************************************************
    // declarations
    // ********************************************************
    rxirq_pkg::rxirq_bus_state_type bus_state_ff;
    rxirq_pkg::rxirq_byte_type idx_ff;
    logic wr_ff;
    logic rd_ff;
    logic addr_ok_ff;
    logic hresp_ff;
    rxirq_pkg::rxirq_byte_type rx_mode_ff;
    rxirq_pkg::rxirq_byte_type flags_ff;
    rxirq_pkg::rxirq_byte_type mask_ff;
    rxirq_pkg::rxirq_byte_type trig_hi_ff;
    rxirq_pkg::rxirq_byte_type trig_lo_ff;
    rxirq_pkg::rxirq_byte_type buf_ctl_ff;
    rxirq_pkg::rxirq_byte_type chstat_ff;
    rxirq_pkg::rxirq_byte_type err_raw_ff;
    rxirq_pkg::rxirq_byte_type err_mask_ff;
    rxirq_pkg::rxirq_byte_type buf_index_ff;
    rxirq_pkg::rxirq_byte_type cond;
    rxirq_pkg::rxirq_byte_type fire;
    rxirq_pkg::rxirq_byte_type nxt_flags;
    rxirq_pkg::rxirq_byte_type err_shown;
    logic [31:0] nxt_rdata;
    logic addr_phase;
    logic do_write;
    logic flags_read;
    logic sample_err;
    logic int_out_ff;
    logic int_oe_ff;
    logic [9:0] cs_sel;
    logic [1:0] pol;

    // register index from a word address
    function automatic rxirq_pkg::rxirq_byte_type word_index(
        input logic [31:0] addr);
        return addr[9:2];
    endfunction : word_index

    // true when an index lies inside the data buffer window
    function automatic logic in_window(
        input rxirq_pkg::rxirq_byte_type idx);
        return (idx >= `RXIRQ_IDX_BUF_FIRST) &&
               (idx <= `RXIRQ_IDX_BUF_LAST);
    endfunction : in_window

    // true for any index that answers with real content
    function automatic logic mapped(input rxirq_pkg::rxirq_byte_type idx);
        return (idx == `RXIRQ_IDX_RX_MODE) ||
               ((idx >= `RXIRQ_IDX_FLAGS) &&
                (idx <= `RXIRQ_IDX_ERR_MASK)) || in_window(idx);
    endfunction : mapped

    // ********************************************************
    // AHB-Lite slave: one wait cycle in every data phase
    // ********************************************************
    assign addr_phase = hsel && hready && htrans[1];
    assign do_write = (bus_state_ff == rxirq_pkg::RXIRQ_BUS_WAIT) &&
                      wr_ff && addr_ok_ff;
    assign flags_read = (bus_state_ff == rxirq_pkg::RXIRQ_BUS_WAIT) &&
                        rd_ff && (idx_ff == `RXIRQ_IDX_FLAGS);

    // phase tracking; the wait cycle lets buffer storage answer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state_ff <= rxirq_pkg::RXIRQ_BUS_IDLE;
            hreadyout <= 1'b1;
        end else if (bus_state_ff == rxirq_pkg::RXIRQ_BUS_WAIT) begin
            bus_state_ff <= rxirq_pkg::RXIRQ_BUS_IDLE;
            hreadyout <= 1'b1;
        end else if (addr_phase) begin
            bus_state_ff <= rxirq_pkg::RXIRQ_BUS_WAIT;
            hreadyout <= 1'b0;
        end
    end

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_ff <= `RXIRQ_RST_ZERO;
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            addr_ok_ff <= 1'b0;
            buf_index_ff <= `RXIRQ_RST_ZERO;
        end else if (bus_state_ff == rxirq_pkg::RXIRQ_BUS_IDLE) begin
            idx_ff <= word_index(haddr);
            wr_ff <= addr_phase && hwrite;
            rd_ff <= addr_phase && !hwrite;
            addr_ok_ff <= mapped(word_index(haddr));
            if (addr_phase && in_window(word_index(haddr))) begin
                buf_index_ff <= 8'(word_index(haddr) -
                                   `RXIRQ_IDX_BUF_FIRST);
            end
        end
    end

    // response is always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_ff <= 1'b0;
        end else begin
            hresp_ff <= 1'b0;
        end
    end

    // ********************************************************
    // writable registers
    // ********************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_mode_ff <= `RXIRQ_RST_ZERO;
            mask_ff <= `RXIRQ_RST_ZERO;
            trig_hi_ff <= `RXIRQ_RST_ZERO;
            trig_lo_ff <= `RXIRQ_RST_ZERO;
            buf_ctl_ff <= `RXIRQ_RST_BUF_CTL;
            err_mask_ff <= `RXIRQ_RST_ZERO;
        end else if (do_write) begin
            unique case (idx_ff)
                `RXIRQ_IDX_RX_MODE: rx_mode_ff <= hwdata[7:0];
                `RXIRQ_IDX_MASK: mask_ff <= hwdata[7:0];
                `RXIRQ_IDX_TRIG_HI: trig_hi_ff <= hwdata[7:0];
                `RXIRQ_IDX_TRIG_LO: trig_lo_ff <= hwdata[7:0];
                `RXIRQ_IDX_BUF_CTL:
                    buf_ctl_ff <= hwdata[7:0] & `RXIRQ_BUF_CTL_USED;
                `RXIRQ_IDX_ERR_MASK: err_mask_ff <= hwdata[7:0];
                default: ; // read-only or window: write ignored
            endcase
        end
    end

    // ********************************************************
    // receiver errors
    // ********************************************************
    // q-subcode crc at its block boundary
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_raw_ff[`RXIRQ_ERR_SUBCRC] <= 1'b0;
        end else if (qsub_block_strobe) begin
            err_raw_ff[`RXIRQ_ERR_SUBCRC] <= qsub_crc_fail;
        end
    end

    // channel status crc, only meaningful for professional input
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_raw_ff[`RXIRQ_ERR_CSCRC] <= 1'b0;
        end else if (cs_block_strobe) begin
            err_raw_ff[`RXIRQ_ERR_CSCRC] <= cs_crc_fail;
        end
    end

    // lock error follows the pll continuously
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_raw_ff[`RXIRQ_ERR_UNLOCK] <= 1'b0;
            err_raw_ff[7] <= 1'b0;
        end else begin
            err_raw_ff[`RXIRQ_ERR_UNLOCK] <= pll_unlocked;
            err_raw_ff[7] <= 1'b0;
        end
    end

    // per-subframe error bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_raw_ff[`RXIRQ_ERR_VALID] <= 1'b0;
            err_raw_ff[`RXIRQ_ERR_TRUST] <= 1'b0;
            err_raw_ff[`RXIRQ_ERR_LINE] <= 1'b0;
            err_raw_ff[`RXIRQ_ERR_PARITY] <= 1'b0;
        end else if (subframe_strobe) begin
            err_raw_ff[`RXIRQ_ERR_VALID] <= sf_validity;
            err_raw_ff[`RXIRQ_ERR_TRUST] <=
                pll_unlocked | sf_line_code_error;
            err_raw_ff[`RXIRQ_ERR_LINE] <= sf_line_code_error;
            err_raw_ff[`RXIRQ_ERR_PARITY] <= sf_odd_even_fail;
        end
    end

    // only unmasked errors are shown and raise the error interrupt
    assign err_shown = err_raw_ff & err_mask_ff;

    // errors of the arriving subframe, crc bits left out
    assign sample_err = |({1'b0, 1'b0, 1'b0, pll_unlocked, sf_validity,
                           pll_unlocked | sf_line_code_error,
                           sf_line_code_error, sf_odd_even_fail} &
                          err_mask_ff & `RXIRQ_ERR_SAMPLE_MASK);

    rxirq_sample_hold u_hold (
        .hclk(hclk),
        .hresetn(hresetn),
        .sample_strobe(subframe_strobe),
        .sample_in(sf_sample),
        .sample_err(sample_err),
        .hold_mode(rx_mode_ff[`RXIRQ_HOLD_LSB +: 2]),
        .sample_out(sample_out),
        .sample_out_valid(sample_out_valid)
    );

    // ********************************************************
    // decoded channel status of the selected side
    // ********************************************************
    // side fields: aux[9:6] fmt[5] audio[4] copy[3] first[2]
    // general[1] spare[0]
    assign cs_sel = buf_ctl_ff[`RXIRQ_SIDE_BIT] ? cs_side_b :
                    cs_side_a;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chstat_ff <= `RXIRQ_RST_ZERO;
        end else begin
            chstat_ff[7:4] <= cs_sel[9:6];
            chstat_ff[3] <= cs_sel[5];
            chstat_ff[2] <= cs_sel[4];
            if (cs_sel[5] || !receiver_in_use) begin
                chstat_ff[1] <= 1'b1;
                chstat_ff[0] <= 1'b1;
            end else begin
                chstat_ff[1] <= cs_sel[3] | cs_sel[1];
                chstat_ff[0] <= cs_sel[2];
            end
        end
    end

    // ********************************************************
    // interrupt sources, triggers and sticky flags
    // ********************************************************
    always_comb begin
        cond = `RXIRQ_RST_ZERO;
        cond[`RXIRQ_INT_RXERR] = |err_shown;
        cond[`RXIRQ_INT_OVFL] = adc_ovfl_left | adc_ovfl_right;
        cond[`RXIRQ_INT_USER] = user_buf_update;
        cond[`RXIRQ_INT_CBUF] = cbuf_update;
        cond[`RXIRQ_INT_QCH] = qch_update;
        cond[`RXIRQ_INT_UNLOCK] = pll_unlocked;
    end

    rxirq_trigger u_trig (
        .hclk(hclk),
        .hresetn(hresetn),
        .cond(cond),
        .mode_hi(trig_hi_ff),
        .mode_lo(trig_lo_ff),
        .fire(fire)
    );

    // a set in the clearing cycle survives the read
    always_comb begin
        nxt_flags = flags_read ? `RXIRQ_RST_ZERO : flags_ff;
        nxt_flags = (nxt_flags | fire) & mask_ff;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_ff <= `RXIRQ_RST_ZERO;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // ********************************************************
    // interrupt pin: trigger mode says when, polarity says how
    // ********************************************************
    assign pol = rx_mode_ff[`RXIRQ_POL_LSB +: 2];

    // reserved polarity code keeps the pin released
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_out_ff <= 1'b0;
            int_oe_ff <= 1'b1;
        end else begin
            unique case (pol)
                `RXIRQ_POL_HIGH: begin
                    int_out_ff <= |nxt_flags;
                    int_oe_ff <= 1'b1;
                end
                `RXIRQ_POL_LOW: begin
                    int_out_ff <= ~(|nxt_flags);
                    int_oe_ff <= 1'b1;
                end
                `RXIRQ_POL_OPEN: begin
                    int_out_ff <= 1'b0;
                    int_oe_ff <= |nxt_flags;
                end
                default: begin
                    int_out_ff <= 1'b0;
                    int_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    // ********************************************************
    // read data, built in the wait cycle
    // ********************************************************
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (in_window(idx_ff)) begin
            if (buf_ctl_ff[`RXIRQ_CONTENT_BIT]) begin
                nxt_rdata[7:0] = ubuf_byte;
            end else if (buf_ctl_ff[`RXIRQ_WIDTH_BIT]) begin
                nxt_rdata[15:0] = {cbuf_byte_b, cbuf_byte_a};
            end else begin
                nxt_rdata[7:0] = buf_ctl_ff[`RXIRQ_SIDE_BIT] ?
                                 cbuf_byte_b : cbuf_byte_a;
            end
        end else begin
            unique case (idx_ff)
                `RXIRQ_IDX_RX_MODE: nxt_rdata[7:0] = rx_mode_ff;
                `RXIRQ_IDX_FLAGS: nxt_rdata[7:0] = flags_ff;
                `RXIRQ_IDX_MASK: nxt_rdata[7:0] = mask_ff;
                `RXIRQ_IDX_TRIG_HI: nxt_rdata[7:0] = trig_hi_ff;
                `RXIRQ_IDX_TRIG_LO: nxt_rdata[7:0] = trig_lo_ff;
                `RXIRQ_IDX_BUF_CTL: nxt_rdata[7:0] = buf_ctl_ff;
                `RXIRQ_IDX_CHSTAT: nxt_rdata[7:0] = chstat_ff;
                `RXIRQ_IDX_ERR: nxt_rdata[7:0] = err_shown;
                `RXIRQ_IDX_ERR_MASK: nxt_rdata[7:0] = err_mask_ff;
                default: nxt_rdata = 32'h0000_0000; // unmapped
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (bus_state_ff == rxirq_pkg::RXIRQ_BUS_WAIT) begin
            hrdata <= rd_ff ? nxt_rdata : 32'h0000_0000;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign hresp = hresp_ff;
    assign buf_index = buf_index_ff;
    assign pll_tracking_mode = buf_ctl_ff[`RXIRQ_TRACK_LSB +: 2];
    assign buffer_content_select = buf_ctl_ff[`RXIRQ_CONTENT_BIT];
    assign buffer_access_width = buf_ctl_ff[`RXIRQ_WIDTH_BIT];
    assign subframe_side_select = buf_ctl_ff[`RXIRQ_SIDE_BIT];
    assign int_pin_out = int_out_ff;
    assign int_pin_oe = int_oe_ff;

endmodule : rxirq_top

/* design/rxirq_trigger.sv */
`timescale 1ns/1ps
`include "rxirq_defines.svh"

module rxirq_trigger (
    input wire logic hclk,
    input wire logic hresetn,
    input wire rxirq_pkg::rxirq_byte_type cond,
    input wire rxirq_pkg::rxirq_byte_type mode_hi,
    input wire rxirq_pkg::rxirq_byte_type mode_lo,
    output rxirq_pkg::rxirq_byte_type fire
);

    rxirq_pkg::rxirq_byte_type prev_ff;

    // ********************************************************
    // per-source trigger decode
    // ********************************************************
    function automatic logic trig_fire(input logic [1:0] code,
                                       input logic now,
                                       input logic was);
        logic res;
        res = 1'b0;
        unique case (code)
            `RXIRQ_TRIG_RISE: res = now & ~was;
            `RXIRQ_TRIG_FALL: res = ~now & was;
            `RXIRQ_TRIG_LEVEL: res = now;
            default: res = 1'b0; // reserved code never fires
        endcase
        return res;
    endfunction : trig_fire

    // condition history for edge detection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_ff <= `RXIRQ_RST_ZERO;
        end else begin
            prev_ff <= cond;
        end
    end

    // high bit from one register, low bit from the other
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            fire[i] = trig_fire({mode_hi[i], mode_lo[i]}, cond[i],
                                prev_ff[i]);
        end
    end

endmodule : rxirq_trigger

/* inc/rxirq_defines.svh */
`ifndef RXIRQ_DEFINES_SVH
`define RXIRQ_DEFINES_SVH

// ********************************************************
// register indices (byte address is four times the index)
// ********************************************************
`define RXIRQ_IDX_RX_MODE 8'h1e
`define RXIRQ_IDX_FLAGS 8'h20
`define RXIRQ_IDX_MASK 8'h21
`define RXIRQ_IDX_TRIG_HI 8'h22
`define RXIRQ_IDX_TRIG_LO 8'h23
`define RXIRQ_IDX_BUF_CTL 8'h24
`define RXIRQ_IDX_CHSTAT 8'h25
`define RXIRQ_IDX_ERR 8'h26
`define RXIRQ_IDX_ERR_MASK 8'h27
`define RXIRQ_IDX_BUF_FIRST 8'h3a
`define RXIRQ_IDX_BUF_LAST 8'h51

// ********************************************************
// reset values
// ********************************************************
`define RXIRQ_RST_ZERO 8'h00
`define RXIRQ_RST_BUF_CTL 8'h40

// ********************************************************
// interrupt source bit positions
// ********************************************************
`define RXIRQ_INT_RXERR 0
`define RXIRQ_INT_OVFL 1
`define RXIRQ_INT_USER 3
`define RXIRQ_INT_CBUF 4
`define RXIRQ_INT_QCH 5
`define RXIRQ_INT_UNLOCK 7

// ********************************************************
// receiver error bit positions
// ********************************************************
`define RXIRQ_ERR_PARITY 0
`define RXIRQ_ERR_LINE 1
`define RXIRQ_ERR_TRUST 2
`define RXIRQ_ERR_VALID 3
`define RXIRQ_ERR_UNLOCK 4
`define RXIRQ_ERR_CSCRC 5
`define RXIRQ_ERR_SUBCRC 6
`define RXIRQ_ERR_SAMPLE_MASK 8'h1f

// ********************************************************
// field positions of the control registers
// ********************************************************
`define RXIRQ_POL_LSB 2
`define RXIRQ_HOLD_LSB 0
`define RXIRQ_TRACK_LSB 6
`define RXIRQ_CONTENT_BIT 2
`define RXIRQ_WIDTH_BIT 1
`define RXIRQ_SIDE_BIT 0
`define RXIRQ_BUF_CTL_USED 8'hc7

// ********************************************************
// two-bit codes
// ********************************************************
`define RXIRQ_TRIG_RISE 2'h0
`define RXIRQ_TRIG_FALL 2'h1
`define RXIRQ_TRIG_LEVEL 2'h2
`define RXIRQ_POL_HIGH 2'h0
`define RXIRQ_POL_LOW 2'h1
`define RXIRQ_POL_OPEN 2'h2
`define RXIRQ_HOLD_LAST 2'h0
`define RXIRQ_HOLD_ZERO 2'h1
`define RXIRQ_HOLD_PASS 2'h2

`endif

/* inc/rxirq_pkg.sv */
package rxirq_pkg;

    // bus slave phase: idle or one wait cycle of a data phase
    typedef enum logic {
        RXIRQ_BUS_IDLE,
        RXIRQ_BUS_WAIT
    } rxirq_bus_state_type;

    typedef logic [7:0] rxirq_byte_type;
    typedef logic [23:0] rxirq_sample_type;

endpackage : rxirq_pkg

/* testbench/rxirq_host.sv */
`timescale 1ns/1ps
// ****
// host: single word transfers, bounded waits
// ****
module rxirq_host (
    input wire logic hclk,
    input wire logic hready,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic stuck
);
    assign hsize = 3'h2;
    initial {hsel, haddr, htrans, hwrite, hwdata, stuck} = '0;
    // hold each phase until hready is seen high at an edge
    task automatic xfer(input logic w, input logic [7:0] i, logic [31:0] d);
        int n;
        n = 0;
        {hsel, htrans, hwrite} <= {1'b1, 2'h2, w};
        haddr <= {22'h0, i, 2'h0};
        do @(posedge hclk); while (!hready && n++ < 50);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge hclk); while (!hready && n++ < 50);
        stuck <= n >= 50;
    endtask : xfer
endmodule : rxirq_host

/* testbench/rxirq_sva.sv */
`timescale 1ns/1ps
// ****
// bus and sample checks
// ****
module rxirq_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic subframe_strobe,
    input wire logic sample_out_valid
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // a read is taken only while idle, then one wait state
    sequence s_rd; hsel && htrans[1] && hreadyout && !hwrite; endsequence
    sequence s_ws; !hreadyout ##1 hreadyout; endsequence
    property p_ws; hsel && htrans[1] && hreadyout |=> s_ws; endproperty
    a_ws: assert property (p_ws) else $error("wait state");
    property p_ok; hresp == 1'b0; endproperty
    a_ok: assert property (p_ok) else $error("bad response");
    property p_hold; !hreadyout |-> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("data moved");
    property p_flg; s_rd ##0 haddr[9:2] == 8'h20 |-> ##2 hrdata[31:8] == 24'h0;
    endproperty
    a_flg: assert property (p_flg) else $error("flag width");
    property p_un; s_rd ##0 haddr[9:2] == 8'h10 |-> ##2 hrdata == 32'h0;
    endproperty
    a_un: assert property (p_un) else $error("unmapped read");
    property p_ctl; s_rd ##0 haddr[9:2] == 8'h24 |-> ##2 hrdata[5:3] == 3'h0;
    endproperty
    a_ctl: assert property (p_ctl) else $error("reserved bits");
    property p_sv; subframe_strobe |=> sample_out_valid; endproperty
    a_sv: assert property (p_sv) else $error("no sample");
    property p_nv; !subframe_strobe |=> !sample_out_valid; endproperty
    a_nv: assert property (p_nv) else $error("extra sample");
endmodule : rxirq_sva
bind rxirq_top rxirq_sva u_sva (.*);

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, stuck;
    logic [31:0] haddr, hwdata, hrdata, rnd, q[$];
    logic [7:0] e, ri[7] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h27, 8'h10};
    logic [1:0] htrans, pll_tracking_mode;
    logic [2:0] hsize;
    logic [4:0] ev;
    logic [9:0] cs_side_a, cs_side_b, s;
    logic user_buf_update, cbuf_update, qch_update, adc_ovfl_left, pe, stb;
    logic adc_ovfl_right, pll_unlocked, subframe_strobe, sf_validity, rdp;
    logic sf_line_code_error, sf_odd_even_fail, qsub_block_strobe;
    logic qsub_crc_fail, cs_block_strobe, cs_crc_fail, receiver_in_use;
    logic [7:0] cbuf_byte_a, cbuf_byte_b, ubuf_byte, buf_index;
    logic [23:0] sf_sample, sample_out, lg;
    logic buffer_content_select, buffer_access_width, subframe_side_select;
    logic sample_out_valid, int_pin_out, int_pin_oe;
    int mismatches, checks_done;
    // every event and data input follows ev, stb or the random word
    assign {qch_update, cbuf_update, user_buf_update} = ev[4:2];
    assign {adc_ovfl_left, adc_ovfl_right, hready} = {ev[1:0], hreadyout};
    assign {subframe_strobe, qsub_block_strobe, cs_block_strobe} = {3{stb}};
    assign {pll_unlocked, sf_validity, sf_line_code_error} = rnd[5:3];
    assign {sf_odd_even_fail, cs_crc_fail, qsub_crc_fail} = rnd[2:0];
    assign {sf_sample, cs_side_a} = {rnd[31:8], rnd[17:8]};
    assign cs_side_b = rnd[9:0];
    assign {cbuf_byte_a, cbuf_byte_b, ubuf_byte} = {rnd[23:0]};
    assign receiver_in_use = rnd[31];
    rxirq_top u_dut (.*);
    rxirq_host u_host (.*);
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    // xorshift step feeding every random design input
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction : xs
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            mismatches++;
            $display("CHECK FAILED %0t %h %h", $time, seen, want);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    task automatic rd(input logic [7:0] i, input logic [31:0] want);
        q.push_back(want);
        u_host.xfer(1'b0, i, 32'h0);
    endtask : rd
    // a completed read is compared with the oldest note
    always @(posedge hclk) begin
        if (rdp && hreadyout) chk(hrdata, q.pop_front());
        if (hreadyout) rdp = hsel && htrans[1] && !hwrite;
        if (stuck) mismatches++;
        if (stuck) results();
    end
    initial begin
        {hresetn, ev, stb, rdp, lg, mismatches, checks_done} = '0;
        rnd = 32'hbf18;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (ri[k]) rd(ri[k], ri[k] == 8'h24 ? 8'h40 : 8'h0);
        u_host.xfer(1'b1, 8'h21, 8'h3b);
        for (int c = 0; c < 3; c++) begin
            u_host.xfer(1'b1, 8'h22, c[1] ? 8'hff : 8'h0);
            u_host.xfer(1'b1, 8'h23, c[0] ? 8'hff : 8'h0);
            rd(8'h20, 8'h0);
            ev <= 5'h1f;
            repeat (3) @(posedge hclk);
            rd(8'h20, c != 1 ? 8'h3a : 8'h0);
            ev <= 5'h0;
            repeat (3) @(posedge hclk);
            rd(8'h20, c != 0 ? 8'h3a : 8'h0);
        end
        $display("trigger modes done");
        u_host.xfer(1'b1, 8'h27, 8'h77);
        pe = 1'b0;
        for (int i = 0; i < 6; i++) begin
            rnd <= xs(rnd);
            u_host.xfer(1'b1, 8'h1e, {4'h0, 2'(i % 3), 2'(i % 3)});
            stb <= 1'b1;
            @(posedge hclk);
            stb <= 1'b0;
            repeat (2) @(posedge hclk);
            e = {1'b0, rnd[0], rnd[1], rnd[5], rnd[4],
                 rnd[5] | rnd[3], rnd[3:2]};
            e = e & 8'h77;
            chk(sample_out, !e[4:0] || i % 3 == 2 ? rnd[31:8] :
                i % 3 ? 24'h0 : lg);
            if (!e[4:0]) lg = rnd[31:8];
            rd(8'h26, e);
            rd(8'h20, {7'h0, pe | (e != 0)});
            chk({int_pin_out, int_pin_oe}, i % 3 == 2 ? {1'b0, e != 0} :
                {(e != 0) ^ (i % 3 == 1), 1'b1});
            pe = e != 0;
        end
        $display("receiver errors done");
        for (int j = 0; j < 8; j++) begin
            u_host.xfer(1'b1, 8'h24, {5'h8, j[2:0]});
            rd(8'h24, {5'h8, j[2:0]});
            s = j[0] ? cs_side_b : cs_side_a;
            rd(8'h25, {s[9:4], |{s[5], s[3], s[1], !receiver_in_use},
                |{s[5], s[2], !receiver_in_use}});
            rd(8'(8'h3a + j), j[2] ? ubuf_byte :
                j[1] ? {cbuf_byte_b, cbuf_byte_a} :
                j[0] ? cbuf_byte_b : cbuf_byte_a);
            chk({buf_index, pll_tracking_mode, buffer_content_select,
                buffer_access_width, subframe_side_select},
                {8'(j), 2'h1, j[2:0]});
        end
        $display("buffer window done");
        results();
    end
endmodule : tb
